// file: rtl/t1mon_params.svh
// Constants of the T1 receive alarm and error monitor.
// Behaviour
// R1: Counters saturate at 15; further events raise interrupt.
// R2: Host presets counters; counting continues upward.
// R3: One byte: out-of-frame high, superframe low.
// R4: Upper counter counts every out-of-frame event.
// R5: Lower counter source depends on mode, select.
// R6: No counter increments while loss of sync.
// R7: Loss of sync spans resync; status latches it.
// R8: Auto mode: two of four errors resync.
// R9: Manual mode: resync only on control edge.
// R10: Yellow output follows condition; status latches it.
// R11: 24-frame yellow: sixteen 00 FF sets.
// R12: 12-frame yellow: bit 2 run or S-bit.
// R13: Violation flag one bit; skip substitution codes.
// R14: Frame error flag two bits on F error.
// R15: 24-frame CRC error gives one-bit pulse.
// R16: Carrier loss after 32 zeros, clears on one.
// R17: Reset clears registers, forces receive resync.
// R18: Controller holds reset, then rewrites control.
// R19: Port select low selects hardware mode.
// R20: Hardware pins drive five mode bits.
// R21: Both suppression pins high: loopback, latch modes.
// R22: Hardware mode: robbed bit on, rest cleared.
// R23: Saturation status set when either counter saturates; the code sets it only on a further event at 15.
// R24: Overflow clears only on non-all-ones preset.
// R25: Counter byte write loads both nibbles together.
`ifndef T1MON_PARAMS_SVH
`define T1MON_PARAMS_SVH
`define T1MON_OFS_COUNTERS 8'h00
`define T1MON_OFS_STATUS 8'h04
`define T1MON_OFS_MASK 8'h08
`define T1MON_OFS_RXCTL 8'h0C
`define T1MON_OFS_COMMON 8'h10
`define T1MON_OFS_TXCTL 8'h14
`define T1MON_ST_LOS 0
`define T1MON_ST_FERR 3
`define T1MON_ST_CL 4
`define T1MON_ST_YEL 5
`define T1MON_ST_SAT 6
`define T1MON_MASK_SAT 6
`define T1MON_RXC_RESYNC 0
`define T1MON_RXC_MANUAL 1
`define T1MON_RXC_ESEL 3
`define T1MON_CC_LOOP 0
`define T1MON_CC_ZS 1
`define T1MON_CC_B8ZS 2
`define T1MON_CC_YFMT 3
`define T1MON_CC_MODE24 4
`define T1MON_TC_YEL 0
`define T1MON_TC_SBIT 2
`define T1MON_TC_RBS 4
`define T1MON_HW_SBIT 0
`define T1MON_HW_MODE24 1
`define T1MON_HW_TXYEL 2
`define T1MON_HW_ZS 3
`define T1MON_HW_B8ZS 4
`define T1MON_NIB_MAX 4'hF
`define T1MON_OOF_ERRS 3'h2
`define T1MON_ZERO_LAST 6'h1F
`define T1MON_ZERO_RUN 6'h20
`define T1MON_YEL_SETS 5'h10
`define T1MON_YEL_GAP 5'h10
`define T1MON_LINK_PAT 16'h00FF
`define T1MON_BIT2_LAST 9'h0FF
`define T1MON_BIT2_RUN 9'h100
`define T1MON_FERR_BITS 2'h2
`endif

// file: rtl/t1mon_pkg.sv
// Types shared by the T1 receive alarm and error monitor.
package t1mon_pkg;
    typedef enum logic [0:0] {
        SYNC_LOCKED = 1'b0,
        SYNC_HUNT = 1'b1
    } t1mon_sync_state_type;

    typedef struct packed {
        logic clk;
        logic line_bit;
        logic serial_bit;
        logic fbit_time;
        logic fpat_bit;
        logic fpat_err;
        logic fs_bit;
        logic fs_err;
        logic frame12;
        logic crc_err;
        logic bpv;
        logic b8zs_code;
        logic link_strobe;
        logic link_bit;
        logic bit2_time;
        logic sync_found;
        logic port_select;
        logic [4:0] hw_mode;
    } t1mon_pins_type;
endpackage

// file: rtl/t1mon_cnt_if.sv
// Control and state of one saturating error counter.
`timescale 1ns/10ps
interface t1mon_cnt_if;
    logic load;
    logic [3:0] load_val;
    logic inc;
    logic [3:0] count;
    logic sat_hit;
    modport ctl (output load, output load_val, output inc, input count, input sat_hit);
    modport cnt (input load, input load_val, input inc, output count, output sat_hit);
endinterface

// file: rtl/t1mon_sync2.sv
// Two-flop synchroniser for a vector of unrelated pin levels.
`timescale 1ns/10ps
module t1mon_sync2 #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// file: rtl/t1mon_sat_cnt.sv
// Presettable 4-bit up counter that stops at its maximum.
`timescale 1ns/10ps
`include "t1mon_params.svh"
module t1mon_sat_cnt (
    input wire logic core_clk,
    input wire logic nrst,
    t1mon_cnt_if.cnt port
);
    logic [3:0] count_q;

    assign port.count = count_q;
    // An event at the maximum, or together with a preset of all ones, is the overflow.
    assign port.sat_hit = port.inc && ((port.load ? port.load_val : count_q) == `T1MON_NIB_MAX);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            count_q <= 4'h0;
        // R25: preset keeps increment
        else if (port.load)
            count_q <= (port.inc && port.load_val != `T1MON_NIB_MAX) ?
                       port.load_val + 4'h1 : port.load_val;
        // R1: stop at fifteen
        else if (port.inc && count_q != `T1MON_NIB_MAX)
            count_q <= count_q + 4'h1;
    end
endmodule

// file: rtl/t1mon_top.sv
// Receive alarm and error monitor with hardware mode and AHB-Lite registers.
`timescale 1ns/10ps
`include "t1mon_params.svh"
module t1mon_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rx_clk,
    input wire logic rx_line_bit,
    input wire logic rx_serial_out,
    input wire logic rx_fbit_time,
    input wire logic rx_fpat_bit,
    input wire logic rx_fpat_err,
    input wire logic rx_fs_bit,
    input wire logic rx_fs_err,
    input wire logic rx_frame12,
    input wire logic rx_crc_err,
    input wire logic rx_bpv,
    input wire logic rx_b8zs_code,
    input wire logic rx_link_strobe,
    input wire logic rx_facility_link,
    input wire logic rx_bit2_time,
    input wire logic rx_sync_found,
    input wire logic port_select,
    input wire logic [4:0] hw_mode_pins,
    output logic loss_of_sync,
    output logic yellow_alarm_detect,
    output logic bipolar_violation_flag,
    output logic frame_error_flag,
    output logic carrier_loss,
    output logic count_irq,
    output logic [7:0] common_control,
    output logic [7:0] tx_control
);
    t1mon_pkg::t1mon_pins_type raw, s;
    t1mon_pkg::t1mon_sync_state_type state_q, state_d;
    logic [7:0] mask_q, rxctl_q, common_q, txctl_q, stat_q;
    logic ap_wr_q, rd_fire, cnt_wr, stat_clr, hw_mode;
    logic [7:0] ap_addr_q;
    logic rxc_q, rise, fall, post_rst_q, resync_prev_q, start;
    logic [3:0] hist_q;
    logic oof_evt, crc_evt, ft_evt, fs_evt, ferr_test, cl_start;
    logic hi_pend_q, lo_pend_q, sat_pend;
    logic [5:0] zrun_q;
    logic [1:0] ferr_cnt_q;
    logic crcp_q;
    logic [15:0] lsh_q;
    logic [4:0] sets_q, gap_q;
    logic [8:0] run_q;
    logic los_q, yel_q, bpv_q, cl_q, ferr_q, irq_q, hrv_q;
    logic [31:0] hrdata_q;
    logic mode24, yfmt, auto;

    t1mon_cnt_if hi ();
    t1mon_cnt_if lo ();

    assign raw = {rx_clk, rx_line_bit, rx_serial_out, rx_fbit_time, rx_fpat_bit, rx_fpat_err,
                  rx_fs_bit, rx_fs_err, rx_frame12, rx_crc_err, rx_bpv, rx_b8zs_code,
                  rx_link_strobe, rx_facility_link, rx_bit2_time, rx_sync_found,
                  port_select, hw_mode_pins};

    // Clock and qualifiers share one synchroniser so they stay aligned.
    t1mon_sync2 #(.W($bits(t1mon_pkg::t1mon_pins_type))) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .d(raw),
        .q(s)
    );

    t1mon_sat_cnt u_hi (
        .core_clk(core_clk),
        .nrst(nrst),
        .port(hi.cnt)
    );

    t1mon_sat_cnt u_lo (
        .core_clk(core_clk),
        .nrst(nrst),
        .port(lo.cnt)
    );

    function automatic logic [2:0] popcnt4(input logic [3:0] v);
        popcnt4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
        is_addr = (a == ofs);
    endfunction

    // R19: port select low
    assign hw_mode = !s.port_select;
    assign mode24 = common_q[`T1MON_CC_MODE24];
    assign yfmt = common_q[`T1MON_CC_YFMT];
    assign auto = !rxctl_q[`T1MON_RXC_MANUAL];
    assign rise = s.clk && !rxc_q;
    assign fall = !s.clk && rxc_q;

    // Bus slave: zero wait states, write data applied in the data phase.
    assign rd_fire = hsel && hready && htrans[1] && !hwrite;
    assign cnt_wr = ap_wr_q && !hw_mode && is_addr(ap_addr_q, `T1MON_OFS_COUNTERS);
    assign stat_clr = rd_fire && is_addr(haddr[7:0], `T1MON_OFS_STATUS);
    assign sat_pend = hi_pend_q || lo_pend_q;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hrv_q <= 1'b0;
        end
        else
        begin
            ap_wr_q <= hsel && hready && htrans[1] && hwrite;
            ap_addr_q <= haddr[7:0];
            hrv_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
            if (rd_fire)
            begin
                case (haddr[7:0])
                    // R3: both nibbles together
                    `T1MON_OFS_COUNTERS: hrdata_q[7:0] <= {hi.count, lo.count};
                    // R23: saturation status bit
                    `T1MON_OFS_STATUS: hrdata_q[7:0] <= stat_q | {1'b0, sat_pend, 6'h00};
                    `T1MON_OFS_MASK: hrdata_q[7:0] <= mask_q;
                    `T1MON_OFS_RXCTL: hrdata_q[7:0] <= rxctl_q;
                    `T1MON_OFS_COMMON: hrdata_q[7:0] <= common_q;
                    `T1MON_OFS_TXCTL: hrdata_q[7:0] <= txctl_q;
                    default: hrdata_q[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // R17: registers cleared
    always_ff @(posedge core_clk)
    begin
        if (!nrst || hw_mode)
        begin
            mask_q <= 8'h00;
            rxctl_q <= 8'h00;
        end
        else if (ap_wr_q && is_addr(ap_addr_q, `T1MON_OFS_MASK))
            mask_q <= hwdata[7:0];
        else if (ap_wr_q && is_addr(ap_addr_q, `T1MON_OFS_RXCTL))
            rxctl_q <= hwdata[7:0];
    end

    // R20: pins drive mode bits
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            common_q <= 8'h00;
            txctl_q <= 8'h00;
        end
        else if (hw_mode)
        begin
            common_q <= 8'h00;
            common_q[`T1MON_CC_MODE24] <= s.hw_mode[`T1MON_HW_MODE24];
            // R21: loopback keeps suppression mode
            if (s.hw_mode[`T1MON_HW_ZS] && s.hw_mode[`T1MON_HW_B8ZS])
            begin
                common_q[`T1MON_CC_LOOP] <= 1'b1;
                common_q[`T1MON_CC_ZS] <= common_q[`T1MON_CC_ZS];
                common_q[`T1MON_CC_B8ZS] <= common_q[`T1MON_CC_B8ZS];
            end
            else
            begin
                common_q[`T1MON_CC_ZS] <= s.hw_mode[`T1MON_HW_ZS];
                common_q[`T1MON_CC_B8ZS] <= s.hw_mode[`T1MON_HW_B8ZS];
            end
            // R22: robbed bit forced on
            txctl_q <= 8'h00;
            txctl_q[`T1MON_TC_RBS] <= 1'b1;
            txctl_q[`T1MON_TC_SBIT] <= s.hw_mode[`T1MON_HW_SBIT];
            txctl_q[`T1MON_TC_YEL] <= s.hw_mode[`T1MON_HW_TXYEL];
        end
        else if (ap_wr_q && is_addr(ap_addr_q, `T1MON_OFS_COMMON))
            common_q <= hwdata[7:0];
        else if (ap_wr_q && is_addr(ap_addr_q, `T1MON_OFS_TXCTL))
            txctl_q <= hwdata[7:0];
    end

    // Framing error history over the last four pattern bits.
    assign ft_evt = rise && s.fbit_time && s.fpat_bit && s.fpat_err;
    assign fs_evt = rise && s.fbit_time && s.fs_bit && s.fs_err;
    // R8: two of four errors
    assign oof_evt = rise && s.fbit_time && s.fpat_bit &&
                     popcnt4({hist_q[2:0], s.fpat_err}) >= `T1MON_OOF_ERRS;
    assign crc_evt = fall && mode24 && s.crc_err;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            hist_q <= 4'h0;
        else if (oof_evt)
            hist_q <= 4'h0;
        else if (rise && s.fbit_time && s.fpat_bit)
            hist_q <= {hist_q[2:0], s.fpat_err};
    end

    // R2: host preset
    assign hi.load = cnt_wr || hw_mode;
    assign lo.load = cnt_wr || hw_mode;
    assign hi.load_val = hw_mode ? 4'h0 : hwdata[7:4];
    assign lo.load_val = hw_mode ? 4'h0 : hwdata[3:0];
    // R6: inhibit while resyncing
    // R4: every out-of-frame event
    assign hi.inc = !los_q && oof_evt;
    // R5: lower counter source
    assign lo.inc = !los_q && (mode24 ? (oof_evt || crc_evt) :
                    (ft_evt || (rxctl_q[`T1MON_RXC_ESEL] && fs_evt)));

    // R24: overflow cleared only by a preset
    always_ff @(posedge core_clk)
    begin
        if (!nrst || hw_mode)
        begin
            hi_pend_q <= 1'b0;
            lo_pend_q <= 1'b0;
        end
        else
        begin
            if (hi.sat_hit)
                hi_pend_q <= 1'b1;
            else if (cnt_wr && hwdata[7:4] != `T1MON_NIB_MAX)
                hi_pend_q <= 1'b0;
            if (lo.sat_hit)
                lo_pend_q <= 1'b1;
            else if (cnt_wr && hwdata[3:0] != `T1MON_NIB_MAX)
                lo_pend_q <= 1'b0;
        end
    end

    // R1: masked overflow interrupt
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            irq_q <= 1'b0;
        else
            irq_q <= sat_pend && mask_q[`T1MON_MASK_SAT];
    end

    // R9: resync sources
    assign start = post_rst_q || (rxctl_q[`T1MON_RXC_RESYNC] && !resync_prev_q) ||
                   (auto && (oof_evt || cl_start));

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            t1mon_pkg::SYNC_LOCKED:
                if (start)
                    state_d = t1mon_pkg::SYNC_HUNT;
            t1mon_pkg::SYNC_HUNT:
                if (!start && rise && s.sync_found)
                    state_d = t1mon_pkg::SYNC_LOCKED;
            default:
                state_d = t1mon_pkg::SYNC_HUNT;
        endcase
    end

    // R7: loss of sync spans resync
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state_q <= t1mon_pkg::SYNC_LOCKED;
            los_q <= 1'b0;
            post_rst_q <= 1'b1;
            resync_prev_q <= 1'b0;
            rxc_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            los_q <= (state_d == t1mon_pkg::SYNC_HUNT);
            post_rst_q <= 1'b0;
            resync_prev_q <= rxctl_q[`T1MON_RXC_RESYNC];
            rxc_q <= s.clk;
        end
    end

    // R16: zero run detect
    assign cl_start = rise && !s.line_bit && zrun_q == `T1MON_ZERO_LAST;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            zrun_q <= 6'h00;
            cl_q <= 1'b0;
        end
        else if (rise)
        begin
            if (s.line_bit)
            begin
                zrun_q <= 6'h00;
                cl_q <= 1'b0;
            end
            else if (zrun_q != `T1MON_ZERO_RUN)
                zrun_q <= zrun_q + 6'h01;
            if (cl_start)
                cl_q <= 1'b1;
        end
    end

    // R13: violation flag per bit
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            bpv_q <= 1'b0;
        else if (rise)
            bpv_q <= s.bpv && !(common_q[`T1MON_CC_B8ZS] && s.b8zs_code);
    end

    // R14: framing bit test
    assign ferr_test = mode24 ? (s.fpat_bit && s.fpat_err) :
                       ((s.fpat_bit && s.fpat_err) || (s.fs_bit && s.fs_err)) &&
                       !(s.frame12 && yfmt);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ferr_cnt_q <= 2'h0;
            crcp_q <= 1'b0;
            ferr_q <= 1'b0;
        end
        else
        begin
            if (rise && s.fbit_time && ferr_test)
                ferr_cnt_q <= `T1MON_FERR_BITS;
            else if (rise && ferr_cnt_q != 2'h0)
                ferr_cnt_q <= ferr_cnt_q - 2'h1;
            // R15: CRC pulse from falling edge
            if (fall)
                crcp_q <= mode24 && s.crc_err;
            ferr_q <= (ferr_cnt_q != 2'h0) || crcp_q;
        end
    end

    // R10: yellow follows condition
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            yel_q <= 1'b0;
            lsh_q <= 16'h0000;
            sets_q <= 5'h00;
            gap_q <= 5'h00;
            run_q <= 9'h000;
        end
        // R11: sixteen pattern sets
        else if (mode24)
        begin
            if (rise && s.link_strobe)
            begin
                lsh_q <= {lsh_q[14:0], s.link_bit};
                if ({lsh_q[14:0], s.link_bit} == `T1MON_LINK_PAT)
                begin
                    gap_q <= 5'h00;
                    if (sets_q != `T1MON_YEL_SETS)
                        sets_q <= sets_q + 5'h01;
                    if (sets_q == `T1MON_YEL_SETS - 5'h01)
                        yel_q <= 1'b1;
                end
                else if (gap_q == `T1MON_YEL_GAP - 5'h01)
                begin
                    sets_q <= 5'h00;
                    yel_q <= 1'b0;
                end
                else
                    gap_q <= gap_q + 5'h01;
            end
        end
        // R12: bit 2 run or frame 12 S-bit
        else if (!yfmt)
        begin
            if (rise && s.bit2_time)
            begin
                if (s.serial_bit)
                begin
                    run_q <= 9'h000;
                    yel_q <= 1'b0;
                end
                else
                begin
                    if (run_q != `T1MON_BIT2_RUN)
                        run_q <= run_q + 9'h001;
                    if (run_q == `T1MON_BIT2_LAST)
                        yel_q <= 1'b1;
                end
            end
        end
        else if (rise && s.fbit_time && s.frame12 && s.fs_bit)
            yel_q <= s.serial_bit;
    end

    // Latched status: set while the alarm stands; the set wins over a read.
    always_ff @(posedge core_clk)
    begin
        if (!nrst || hw_mode)
            stat_q <= 8'h00;
        else
        begin
            stat_q <= stat_clr ? 8'h00 : stat_q;
            if (los_q)
                stat_q[`T1MON_ST_LOS] <= 1'b1;
            if (ferr_q)
                stat_q[`T1MON_ST_FERR] <= 1'b1;
            if (cl_q)
                stat_q[`T1MON_ST_CL] <= 1'b1;
            if (yel_q)
                stat_q[`T1MON_ST_YEL] <= 1'b1;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hrv_q;
    assign hresp = 1'b0;
    assign loss_of_sync = los_q;
    assign yellow_alarm_detect = yel_q;
    assign bipolar_violation_flag = bpv_q;
    assign frame_error_flag = ferr_q;
    assign carrier_loss = cl_q;
    assign count_irq = irq_q;
    assign common_control = common_q;
    assign tx_control = txctl_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sat_hold_a: assert property ((hi.count == `T1MON_NIB_MAX) && !hi.load |=> hi.count == `T1MON_NIB_MAX) // R1
        else $error("upper counter left saturation");
    cnt_inhibit_a: assert property (los_q && !hi.load |=> $stable(hi.count) && $stable(lo.count)) // R6
        else $error("counter moved during resync");
    pend_read_a: assert property (sat_pend && stat_clr && !cnt_wr && !hw_mode |=> sat_pend) // R24
        else $error("overflow cleared by status read");
    los_auto_a: assert property (auto && oof_evt |=> los_q) // R8
        else $error("out-of-frame did not start resync");
    los_manual_a: assert property (!auto && !start && !los_q |=> !los_q) // R9
        else $error("manual mode resync without request");
    ferr_len_a: assert property (rise && s.fbit_time && ferr_test |=> ferr_cnt_q == `T1MON_FERR_BITS) // R14
        else $error("frame error not two bits");
    cl_set_a: assert property (cl_start |=> cl_q) // R16
        else $error("carrier loss missed 32nd zero");
    bpv_b8zs_a: assert property (rise && common_q[`T1MON_CC_B8ZS] && s.b8zs_code |=> !bpv_q) // R13
        else $error("substitution code flagged");
    wr_both_a: assert property (cnt_wr && !hi.inc && !lo.inc |=>
        {hi.count, lo.count} == $past(hwdata[7:0])) // R25
        else $error("counter byte not loaded whole");
    hw_clear_a: assert property (hw_mode |=> rxctl_q == 8'h00 && txctl_q[`T1MON_TC_RBS]) // R22
        else $error("hardware mode control wrong");
    rst_resync_a: assert property (post_rst_q |=> los_q) // R17
        else $error("no resync after reset");
endmodule

// file: tb/t1mon_line_model.sv
// Model of the receive line interface and synchroniser.
`timescale 1ns/10ps
module t1mon_line_model (
    input wire logic zeros,
    input wire logic ferr,
    input wire logic found,
    output logic rx_clk,
    output logic line_bit,
    output logic fbit,
    output logic fpat_err,
    output logic sync_found,
    output logic [9:0] misc
);
    int pos = 0;
    initial
    begin
        {rx_clk, fbit, fpat_err, sync_found, misc} = '0;
        line_bit = 1'b1;
        forever #100 rx_clk = ~rx_clk;
    end
    // Shortened frames keep the run brief; every eighth bit is an F-bit.
    always @(negedge rx_clk)
    begin
        pos <= (pos + 1) % 8;
        line_bit <= ~zeros;
        fbit <= (pos == 7);
        fpat_err <= ferr && (pos == 7);
        sync_found <= found;
        misc <= 10'($urandom);
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the receive alarm and error monitor.
`timescale 1ns/10ps
module testbench;
    logic core_clk, nrst, hsel, hwrite, zeros, ferr, found, port_select;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0] htrans;
    logic hreadyout, rx_clk, line_bit, fbit, fpat_err, sync_found, los, carrier, irq, bpv, ferf;
    logic [9:0] misc;
    logic [4:0] pins;
    logic [7:0] cc, tc, p;
    int errors = 0;
    int checks = 0;
    t1mon_top u_t1mon_top (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .rx_clk,
        .rx_line_bit(line_bit), .rx_serial_out(misc[0]), .rx_fbit_time(fbit),
        .rx_fpat_bit(fbit), .rx_fpat_err(fpat_err), .rx_fs_bit(misc[1]), .rx_fs_err(misc[2]),
        .rx_frame12(misc[3]), .rx_crc_err(misc[4]), .rx_bpv(misc[5]), .rx_b8zs_code(misc[6]),
        .rx_link_strobe(misc[7]), .rx_facility_link(misc[8]), .rx_bit2_time(misc[9]),
        .rx_sync_found(sync_found), .port_select, .hw_mode_pins(pins), .loss_of_sync(los),
        .yellow_alarm_detect(), .bipolar_violation_flag(bpv), .frame_error_flag(ferf),
        .carrier_loss(carrier), .count_irq(irq), .common_control(cc), .tx_control(tc));
    t1mon_line_model u_t1mon_line_model (.zeros, .ferr, .found, .rx_clk, .line_bit, .fbit,
        .fpat_err, .sync_found, .misc);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    // Four errored pattern bits give two out-of-frame events.
    task automatic errs();
        ferr <= 1'b1;
        // Flags are looked at between their update and the next line bit.
        repeat (4)
        begin
            @(posedge fbit);
            #175;
            chk(bpv, misc[5]);
            #125;
            chk(ferf, 1'b1);
        end
        ferr <= 1'b0;
        repeat (16) @(posedge rx_clk);
        @(posedge core_clk);
    endtask
    function automatic logic [3:0] sat(input logic [3:0] v, input int n);
        return (v + n > 15) ? 4'hF : 4'(v + n);
    endfunction
    task automatic give_verdict();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial
    begin
        #2000000;
        errors++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'h7368e391));
        {nrst, hsel, hwrite, htrans, haddr, hwdata, zeros, ferr} = '0;
        {found, port_select, pins} = 7'h60;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (40) @(posedge rx_clk);
        @(posedge core_clk);
        chk(los, 1'b0);
        ahb(1'b0, 8'h00, 8'h00);
        chk(rdat, 32'h0);
        ahb(1'b0, 8'h1C, 8'h00);
        chk(rdat, 32'h0);
        ahb(1'b1, 8'h0C, 8'h02);
        zeros <= 1'b1;
        repeat (30) @(posedge rx_clk);
        chk(carrier, 1'b0);
        repeat (4) @(posedge rx_clk);
        chk(carrier, 1'b1);
        chk(los, 1'b0);
        zeros <= 1'b0;
        repeat (3) @(posedge rx_clk);
        chk(carrier, 1'b0);
        @(posedge core_clk);
        ahb(1'b1, 8'h08, 8'h40);
        ahb(1'b1, 8'h00, 8'hEC);
        errs();
        ahb(1'b0, 8'h00, 8'h00);
        chk(rdat, 32'hFF);
        chk(irq, 1'b1);
        ahb(1'b0, 8'h04, 8'h00);
        chk(rdat[6], 1'b1);
        chk(irq, 1'b1);
        ahb(1'b1, 8'h00, 8'h00);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'b0);
        repeat (3)
        begin
            p = 8'($urandom) & 8'h77;
            ahb(1'b1, 8'h00, p);
            ahb(1'b0, 8'h00, 8'h00);
            chk(rdat, {24'h0, p});
            errs();
            ahb(1'b0, 8'h00, 8'h00);
            chk(rdat, {24'h0, sat(p[7:4], 2), sat(p[3:0], 4)});
            chk(irq, 1'b0);
        end
        ahb(1'b1, 8'h0C, 8'h00);
        found <= 1'b0;
        errs();
        chk(los, 1'b1);
        ahb(1'b1, 8'h00, 8'h00);
        errs();
        ahb(1'b0, 8'h00, 8'h00);
        chk(rdat, 32'h0);
        found <= 1'b1;
        repeat (4) @(posedge rx_clk);
        @(posedge core_clk);
        chk(los, 1'b0);
        ahb(1'b1, 8'h0C, 8'h02);
        found <= 1'b0;
        ahb(1'b1, 8'h0C, 8'h03);
        repeat (6) @(posedge core_clk);
        chk(los, 1'b1);
        found <= 1'b1;
        repeat (3)
        begin
            p = 8'($urandom);
            pins <= {p[4] & ~p[3], p[3:0]};
            port_select <= 1'b0;
            repeat (8) @(posedge core_clk);
            chk(cc, {3'h0, pins[1], 1'b0, pins[4], pins[3], pins[4] & pins[3]});
            chk(tc, {3'h0, 1'b1, 1'b0, pins[0], 1'b0, pins[2]});
        end
        // Both suppression pins high: loopback on, the earlier mode kept.
        p = {3'h0, pins};
        pins <= {2'b11, p[2:0]};
        repeat (8) @(posedge core_clk);
        chk(cc, {3'h0, p[1], 1'b0, p[4], p[3], 1'b1});
        ahb(1'b1, 8'h00, 8'h55);
        ahb(1'b0, 8'h00, 8'h00);
        chk(rdat, 32'h0);
        give_verdict();
    end
endmodule
